// *** design/iso_link_pkg.sv ***
/*
 * Constants shared by the isolated line link logic: clock and sample rates,
 * barrier timing, supply thresholds, register map and status bit layout.
 * Assumes a 50 MHz system clock; all counts derive from the times below.
 */
package iso_link_pkg;

    // ************************************************************
    // Clocking
    // ************************************************************
    localparam int CLK_HZ        = 50_000_000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SAMPLE_HZ     = 4_000_000;
    localparam int SAMPLE_DIV    = CLK_HZ / SAMPLE_HZ;

    // ************************************************************
    // Barrier timing (nominal figures, rounded down to cycles)
    // ************************************************************
    localparam int PROP_NS       = 600;
    localparam int PROP_CYC      = PROP_NS / CLK_PERIOD_NS;
    localparam int ENA_NS        = 875;
    localparam int ENA_CYC       = ENA_NS / CLK_PERIOD_NS;
    localparam int TIMEOUT_NS    = 1200;
    localparam int TIMEOUT_CYC   = TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int START_NS      = 1200;
    localparam int START_CYC     = START_NS / CLK_PERIOD_NS;
    localparam int SLOW_EDGE_NS  = 500;
    localparam int SLOW_EDGE_CYC = SLOW_EDGE_NS / CLK_PERIOD_NS;

    // ************************************************************
    // Supply thresholds in millivolts
    // ************************************************************
    localparam int MV_W = 13;
    localparam logic [MV_W-1:0] UV_FALL_LEVEL_MV = 13'h0fa0; // 4000 mV
    localparam logic [MV_W-1:0] UV_RISE_LEVEL_MV = 13'h1068; // 4200 mV

    // ************************************************************
    // Register port
    // ************************************************************
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_MASK   = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_LIVE   = 2'h2;

    localparam int STAT_W       = 5;
    localparam int BIT_UV_LOGIC = 0;
    localparam int BIT_UV_ISO   = 1;
    localparam int BIT_THERMAL  = 2;
    localparam int BIT_TIMEOUT  = 3;
    localparam int BIT_RESUME   = 4;
    localparam logic [STAT_W-1:0] MASK_RESET = 5'h00;

endpackage

// *** design/edge_rate_limiter.sv ***
/*
 * Driver edge shaping: passes the transmit level to the line pair, fast or
 * with a held-off edge in slow mode. Assumes level_i and slow_i are already
 * synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module edge_rate_limiter #(
    parameter int SLOW_CYC = iso_link_pkg::SLOW_EDGE_CYC
) (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic level_i,
    input  wire logic slow_i,
    output var  logic pos_o,
    output var  logic neg_o,
    output var  logic slow_o
);
    localparam int CW = $clog2(SLOW_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(SLOW_CYC - 1);

    logic [CW-1:0] ramp;
    wire           differs  = level_i != pos_o;
    wire           ramp_end = ramp == LAST;
    // Slow mode lets a change through only after a full edge time
    wire           take     = differs && (!slow_i || ramp_end);
    wire  [CW-1:0] next_ramp = (differs && !take) ? ramp + CW'(1) : '0;

    // Output pair stays complementary at every edge
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pos_o  <= 1'b1;
            neg_o  <= 1'b0;
            ramp   <= '0;
            slow_o <= 1'b0;
        end else begin
            ramp   <= next_ramp;
            slow_o <= slow_i;
            if (take) begin
                pos_o <= level_i;
                neg_o <= ~level_i;
            end
        end
    end
endmodule
`default_nettype wire

// *** design/isolated_line_link_fault_logic.sv ***
/*
 * Digital side of an isolated line transceiver: samples transmit data and
 * enable, carries them across a modelled barrier with nominal delays, returns
 * line data, and detects and reports supply, thermal and time-out faults.
 * Assumes pin inputs are asynchronous, supply words come from a converter on
 * clk_i, and the receive-enable pin is resolved outside from the enables.
 */
// The address-and-strobe port and the register offsets were chosen for this implementation.
// Operation
// - Line driver enabled only while transmit enable is high, else high impedance.
// - Logic receive output driven only while receive enable pin is low.
// - Isolated receive output always shows line state, regardless of enable.
// - Slew select low gives slow edges; high or open gives fast edges.
// - Inputs sampled by a free 4 MHz tick asynchronous to data.
// - Samples cross the barrier both ways at once, 600 ns each way.
// - Transmit enable reaches the driver after about 875 ns.
// - Undervoltage sets below lower threshold, clears above upper threshold.
// - Isolated supply undervoltage stops all barrier traffic.
// - Logic side flags time-out when isolated side frames stop arriving.
// - Traffic resumes a start-up time after faults clear.
// - Thermal shutdown disables the driver and reports a fault.
// - All faults shown by weak drive on the receive enable pin.
// - Open or shorted receiver inputs read as high.
// - Weak drive pulls high on fault, low without fault.
// - During a fault the logic receive output is forced high.
`timescale 1ns/1ps
`default_nettype none
module isolated_line_link_fault_logic #(
    parameter int SAMPLE_DIV  = iso_link_pkg::SAMPLE_DIV,
    parameter int PROP_CYC    = iso_link_pkg::PROP_CYC,
    parameter int ENA_CYC     = iso_link_pkg::ENA_CYC,
    parameter int TIMEOUT_CYC = iso_link_pkg::TIMEOUT_CYC,
    parameter int START_CYC   = iso_link_pkg::START_CYC
) (
    input  wire logic                             clk_i,
    input  wire logic                             reset_i,
    input  wire logic                             tx_bit_in_i,
    input  wire logic                             tx_drv_on_i,
    input  wire logic                             rx_out_en_n_flt_i,
    input  wire logic                             slew_select_n_i,
    input  wire logic                             line_above_th_i,
    input  wire logic                             line_below_th_i,
    input  wire logic                             thermal_trip_i,
    input  wire logic [iso_link_pkg::MV_W-1:0]    vcc_mv_i,
    input  wire logic [iso_link_pkg::MV_W-1:0]    vcc_iso_mv_i,
    input  wire logic [iso_link_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [iso_link_pkg::DATA_W-1:0]  wr_data_i,
    input  wire logic                             wr_stb_i,
    input  wire logic                             rd_stb_i,
    output var  logic [iso_link_pkg::DATA_W-1:0]  rd_data_o,
    output var  logic                             irq_o,
    output var  logic                             drv_pos_o,
    output var  logic                             drv_neg_o,
    output var  logic                             drv_oe_o,
    output var  logic                             drv_slow_o,
    output var  logic                             rx_data_out_o,
    output var  logic                             rx_data_oe_o,
    output var  logic                             iso_rx_data_out_o,
    output var  logic                             rx_out_en_n_flt_o,
    output var  logic                             rx_out_en_n_flt_oe_o
);
    // Counter widths follow the timing counts
    localparam int SYN_W  = 7;
    localparam int DIV_W  = $clog2(SAMPLE_DIV);
    localparam int TO_W   = $clog2(TIMEOUT_CYC + 1);
    localparam int ST_W   = $clog2(START_CYC + 1);
    localparam int SW     = iso_link_pkg::STAT_W;

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV - 1);
    localparam logic [TO_W-1:0]  TO_LIM   = TO_W'(TIMEOUT_CYC);
    localparam logic [ST_W-1:0]  ST_LIM   = ST_W'(START_CYC);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    wire  [SYN_W-1:0] pin_raw = {thermal_trip_i, line_below_th_i, line_above_th_i,
                                 slew_select_n_i, rx_out_en_n_flt_i, tx_drv_on_i,
                                 tx_bit_in_i};

    logic [SYN_W-1:0] sync1;
    logic [SYN_W-1:0] sync2;
    logic [SYN_W-1:0] sync3;
    logic [SYN_W-1:0] pin;

    // A change is accepted only once the second and third stages agree
    for (genvar i = 0; i < SYN_W; i++) begin : g_sync
        always_ff @(posedge clk_i) begin
            sync1[i] <= pin_raw[i];
            sync2[i] <= sync1[i];
            sync3[i] <= sync2[i];
            if (reset_i) begin
                pin[i] <= 1'b0;
            end else if (sync2[i] == sync3[i]) begin
                pin[i] <= sync3[i];
            end
        end
    end

    // Filtered levels per function
    wire tx_bit   = pin[0];
    wire tx_on    = pin[1];
    wire en_n     = pin[2];
    wire slew_n   = pin[3];
    wire above_th = pin[4];
    wire below_th = pin[5];
    wire thermal  = pin[6];

    // ************************************************************
    // Sample tick and faults
    // ************************************************************
    // Supply flags start set: fault shows
    logic [DIV_W-1:0] div_cnt;
    logic             uv_logic;
    logic             uv_iso;
    logic [ST_W-1:0]  start_cnt;
    logic             link_up;

    // Free tick: up to one tick of jitter
    wire tick = div_cnt == '0;
    wire [DIV_W-1:0] next_div = (div_cnt == DIV_LAST) ? '0 : div_cnt + DIV_W'(1);

    // Hysteresis: trip below the falling level, release above the rising one
    wire next_uv_logic = uv_logic ? !(vcc_mv_i > iso_link_pkg::UV_RISE_LEVEL_MV)
                                  : (vcc_mv_i < iso_link_pkg::UV_FALL_LEVEL_MV);
    wire next_uv_iso = uv_iso ? !(vcc_iso_mv_i > iso_link_pkg::UV_RISE_LEVEL_MV)
                              : (vcc_iso_mv_i < iso_link_pkg::UV_FALL_LEVEL_MV);

    // Time-out is kept out so frames can
    // still run and clear it
    wire hard_fault = uv_logic | uv_iso | thermal;

    // Hold-off saturates at its limit
    wire start_done = start_cnt == ST_LIM;
    wire [ST_W-1:0] next_start = hard_fault ? '0
                               : start_done ? start_cnt : start_cnt + ST_W'(1);

    // Free sample divider, supply monitors and start-up hold-off
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            div_cnt   <= '0;
            uv_logic  <= 1'b1;
            uv_iso    <= 1'b1;
            start_cnt <= '0;
            link_up   <= 1'b0;
        end else begin
            div_cnt   <= next_div;
            uv_logic  <= next_uv_logic;
            uv_iso    <= next_uv_iso;
            start_cnt <= next_start;
            link_up   <= start_done && !hard_fault;
        end
    end

    // ************************************************************
    // Barrier channel model
    // ************************************************************
    // Each stage carries {valid, level}; a frame is only sent on a tick
    // Far ends keep the last level; the enable drops when the link is lost
    logic [PROP_CYC-1:0][1:0] fwd_data;
    logic [ENA_CYC-1:0][1:0]  fwd_ena;
    logic [PROP_CYC-1:0][1:0] ret_data;
    logic                     iso_bit;
    logic                     iso_on;
    logic                     line_rx;
    logic                     ret_bit;
    logic [TO_W-1:0]          to_cnt;

    // A low isolated supply silences
    // both directions
    wire send = tick && link_up;

    wire fwd_done = fwd_data[PROP_CYC-1][1];
    wire ena_done = fwd_ena[ENA_CYC-1][1];
    wire ret_done = ret_data[PROP_CYC-1][1];
    // Comparator fail-safe: neither threshold crossed reads high
    wire next_line_rx = above_th | ~below_th;

    // Saturates; a return frame restarts it
    wire timeout = to_cnt == TO_LIM;
    wire [TO_W-1:0] next_to = ret_done ? '0 : timeout ? to_cnt : to_cnt + TO_W'(1);

    // Both directions shift every cycle, so traffic is full duplex
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fwd_data <= '0;
            fwd_ena  <= '0;
            ret_data <= '0;
        end else begin
            fwd_data <= {fwd_data[PROP_CYC-2:0], {send, tx_bit}};
            fwd_ena  <= {fwd_ena[ENA_CYC-2:0], {send, tx_on}};
            ret_data <= {ret_data[PROP_CYC-2:0], {send, line_rx}};
        end
    end

    // Far ends hold the last delivered level; losing the link drops the enable
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            iso_bit <= 1'b1;
            iso_on  <= 1'b0;
            line_rx <= 1'b1;
            ret_bit <= 1'b1;
            to_cnt  <= '0;
        end else begin
            line_rx <= next_line_rx;
            to_cnt  <= next_to;
            if (fwd_done) begin
                iso_bit <= fwd_data[PROP_CYC-1][0];
            end
            if (!link_up) begin
                iso_on <= 1'b0;
            end else if (ena_done) begin
                iso_on <= fwd_ena[ENA_CYC-1][0];
            end
            if (ret_done) begin
                ret_bit <= ret_data[PROP_CYC-1][0];
            end
        end
    end

    // ************************************************************
    // Line driver and pin outputs
    // ************************************************************
    // Time-out still reports as a fault
    wire fault = hard_fault | timeout;

    // Select pin is active low
    edge_rate_limiter u_edge (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .level_i (iso_bit),
        .slow_i  (~slew_n),
        .pos_o   (drv_pos_o),
        .neg_o   (drv_neg_o),
        .slow_o  (drv_slow_o)
    );

    // Enable pin doubles as a weak fault output, weakly driven whenever out of reset
    // Driver drops at once on hard fault
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            drv_oe_o             <= 1'b0;
            rx_data_out_o        <= 1'b1;
            rx_data_oe_o         <= 1'b0;
            iso_rx_data_out_o    <= 1'b1;
            rx_out_en_n_flt_o    <= 1'b1;
            rx_out_en_n_flt_oe_o <= 1'b0;
        end else begin
            drv_oe_o             <= iso_on && !hard_fault;
            rx_data_out_o        <= fault | ret_bit;
            rx_data_oe_o         <= ~en_n;
            iso_rx_data_out_o    <= line_rx;
            rx_out_en_n_flt_o    <= fault;
            rx_out_en_n_flt_oe_o <= 1'b1;
        end
    end

    // ************************************************************
    // Register port and interrupt
    // ************************************************************
    // Sticky status, mask, live levels
    // Last levels give rising-edge detect
    logic [SW-1:0] status;
    logic [SW-1:0] mask;
    logic [SW-1:0] prev_ev;

    wire [SW-1:0] ev_level  = {link_up, timeout, thermal, uv_iso, uv_logic};
    wire [SW-1:0] ev_rise   = ev_level & ~prev_ev;

    // Strobe decodes
    wire          rd_status = rd_stb_i && (addr_i == iso_link_pkg::ADDR_STATUS);
    wire          wr_mask   = wr_stb_i && (addr_i == iso_link_pkg::ADDR_MASK);
    // A new event in the clearing read's cycle survives the clear
    wire [SW-1:0] next_status = (rd_status ? '0 : status) | ev_rise;
    wire [SW-1:0] next_mask   = wr_mask ? wr_data_i[SW-1:0] : mask;

    // Unmapped addresses read zero
    wire [SW-1:0] rd_sel = (addr_i == iso_link_pkg::ADDR_STATUS) ? status
                         : (addr_i == iso_link_pkg::ADDR_MASK)   ? mask
                         : (addr_i == iso_link_pkg::ADDR_LIVE)   ? ev_level : '0;
    wire [iso_link_pkg::DATA_W-1:0] next_rd = rd_stb_i ?
                         {{(iso_link_pkg::DATA_W-SW){1'b0}}, rd_sel} : '0;

    // Read data stands one cycle after the strobe; zero otherwise
    // Irq uses next values to stay in step
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            status    <= '0;
            mask      <= iso_link_pkg::MASK_RESET;
            prev_ev   <= '0;
            rd_data_o <= '0;
            irq_o     <= 1'b0;
        end else begin
            status    <= next_status;
            mask      <= next_mask;
            prev_ev   <= ev_level;
            rd_data_o <= next_rd;
            irq_o     <= |(next_status & next_mask);
        end
    end
endmodule
`default_nettype wire

// *** testbench/rs485_bus_model.sv ***
/* Behavioural model of the differential pair and one remote node.
   Assumes the bench keeps the remote node quiet while the block drives. */
`timescale 1ns/1ps
`default_nettype none
module rs485_bus_model (
    input  wire logic drv_pos_i,
    input  wire logic drv_neg_i,
    input  wire logic drv_oe_i,
    input  wire logic rem_on_i,
    input  wire logic rem_bit_i,
    output var  logic above_o,
    output var  logic below_o
);
    // ********
    // Pair level
    // ********
    // Local driver wins; an idle or shorted pair leaves both comparators low
    assign above_o = drv_oe_i ? (drv_pos_i & ~drv_neg_i) : (rem_on_i & rem_bit_i);
    assign below_o = drv_oe_i ? (drv_neg_i & ~drv_pos_i) : (rem_on_i & ~rem_bit_i);
endmodule
`default_nettype wire

// *** testbench/iso_link_props.sv ***
/* Port checker for the isolated line link block.
   Assumes one clock with a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module iso_link_props #(
    parameter int SAMPLE_DIV = iso_link_pkg::SAMPLE_DIV,
    parameter int ENA_CYC    = iso_link_pkg::ENA_CYC
) (
    input wire logic                          clk_i,
    input wire logic                          reset_i,
    input wire logic                          tx_drv_on_i,
    input wire logic                          rx_out_en_n_flt_i,
    input wire logic                          slew_select_n_i,
    input wire logic                          line_above_th_i,
    input wire logic                          line_below_th_i,
    input wire logic                          thermal_trip_i,
    input wire logic [iso_link_pkg::MV_W-1:0] vcc_iso_mv_i,
    input wire logic                          drv_pos_o,
    input wire logic                          drv_neg_o,
    input wire logic                          drv_oe_o,
    input wire logic                          drv_slow_o,
    input wire logic                          rx_data_out_o,
    input wire logic                          rx_data_oe_o,
    input wire logic                          iso_rx_data_out_o,
    input wire logic                          rx_out_en_n_flt_o,
    input wire logic                          rx_out_en_n_flt_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic [7:0] off_cnt;
    // Cycles with enable low; saturates so long idle stretches stay covered
    always_ff @(posedge clk_i) begin
        if (reset_i || tx_drv_on_i) off_cnt <= 8'h00;
        else if (off_cnt != 8'hff) off_cnt <= off_cnt + 8'h01;
    end
    property p_drv_comp; drv_pos_o != drv_neg_o; endproperty
    a_drv_comp: assert property (p_drv_comp)
        else $error("driver pair not complementary");
    property p_drv_off; off_cnt >= 8'(ENA_CYC + SAMPLE_DIV + 8) |-> !drv_oe_o; endproperty
    a_drv_off: assert property (p_drv_off)
        else $error("driver on without enable");
    property p_hot; thermal_trip_i[*8] |=> !drv_oe_o && rx_out_en_n_flt_o; endproperty
    a_hot: assert property (p_hot)
        else $error("thermal trip not acted on");
    property p_uv; (vcc_iso_mv_i < iso_link_pkg::UV_FALL_LEVEL_MV)[*8] |=>
        rx_out_en_n_flt_o && !drv_oe_o; endproperty
    a_uv: assert property (p_uv)
        else $error("low isolated supply not acted on");
    property p_forced; thermal_trip_i[*8] |=> !rx_data_oe_o || rx_data_out_o; endproperty
    a_forced: assert property (p_forced)
        else $error("receive output not forced high");
    property p_rx_off; rx_out_en_n_flt_i[*6] |=> !rx_data_oe_o; endproperty
    a_rx_off: assert property (p_rx_off)
        else $error("receive output driven while disabled");
    property p_rx_on; !rx_out_en_n_flt_i[*6] |=> rx_data_oe_o; endproperty
    a_rx_on: assert property (p_rx_on)
        else $error("receive output not driven");
    property p_iso_hi; !line_below_th_i[*6] |=> iso_rx_data_out_o; endproperty
    a_iso_hi: assert property (p_iso_hi)
        else $error("isolated receive not high");
    property p_iso_lo; (line_below_th_i && !line_above_th_i)[*6] |=> !iso_rx_data_out_o;
    endproperty
    a_iso_lo: assert property (p_iso_lo)
        else $error("isolated receive not low");
    property p_slow; !slew_select_n_i[*6] |=> drv_slow_o; endproperty
    a_slow: assert property (p_slow)
        else $error("slow edges not selected");
    property p_weak; !$past(reset_i) |-> rx_out_en_n_flt_oe_o; endproperty
    a_weak: assert property (p_weak)
        else $error("weak fault drive off");
endmodule
bind isolated_line_link_fault_logic iso_link_props #(
    .SAMPLE_DIV(SAMPLE_DIV), .ENA_CYC(ENA_CYC)) props_inst (.clk_i, .reset_i, .tx_drv_on_i,
    .rx_out_en_n_flt_i, .slew_select_n_i, .line_above_th_i, .line_below_th_i,
    .thermal_trip_i, .vcc_iso_mv_i, .drv_pos_o, .drv_neg_o, .drv_oe_o, .drv_slow_o,
    .rx_data_out_o, .rx_data_oe_o, .iso_rx_data_out_o, .rx_out_en_n_flt_o,
    .rx_out_en_n_flt_oe_o);
`default_nettype wire

// *** testbench/isolated_line_link_fault_logic_tb.sv ***
/* Self-checking bench for the isolated line link block.
   Assumes the pair model and the checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module isolated_line_link_fault_logic_tb;
    localparam int SDIV = 4;
    localparam int ENA  = 6;
    logic        clk_i, reset_i, tx_bit_in_i, tx_drv_on_i, slew_select_n_i, thermal_trip_i;
    logic        wr_stb_i, rd_stb_i, host_oe, host_en, rem_on, rem_bit, above, below;
    logic        irq_o, drv_pos_o, drv_neg_o, drv_oe_o, drv_slow_o, rx_data_out_o, en_pin;
    logic        rx_data_oe_o, iso_rx_data_out_o, flt_o, flt_oe;
    logic [12:0] vcc_mv_i, vcc_iso_mv_i;
    logic [1:0]  addr_i;
    logic [7:0]  wr_data_i, rd_data_o, d;
    int          bad_count, total_checks, n, nf;
    // Row: pin, remote on, remote bit, slew | rx enable, iso rx, rx data, slow
    logic [7:0]  rows [5] = '{8'h7e, 8'h58, 8'h0f, 8'hc1, 8'hf4};
    // Host drive is strong; the weak fault drive shows only once it lets go
    assign en_pin = host_oe ? host_en : (flt_oe ? flt_o : 1'b1);
    wire logic [2:0] mon = {flt_o, drv_pos_o, drv_oe_o};
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    rs485_bus_model rs485_bus_model_inst (.drv_pos_i(drv_pos_o), .drv_neg_i(drv_neg_o),
        .drv_oe_i(drv_oe_o), .rem_on_i(rem_on), .rem_bit_i(rem_bit), .above_o(above),
        .below_o(below));
    isolated_line_link_fault_logic #(.SAMPLE_DIV(SDIV), .PROP_CYC(4), .ENA_CYC(ENA),
        .TIMEOUT_CYC(30), .START_CYC(5)) isolated_line_link_fault_logic_inst (.clk_i,
        .reset_i, .tx_bit_in_i, .tx_drv_on_i, .rx_out_en_n_flt_i(en_pin), .slew_select_n_i,
        .line_above_th_i(above), .line_below_th_i(below), .thermal_trip_i, .vcc_mv_i,
        .vcc_iso_mv_i, .addr_i, .wr_data_i, .wr_stb_i, .rd_stb_i, .rd_data_o, .irq_o,
        .drv_pos_o, .drv_neg_o, .drv_oe_o, .drv_slow_o, .rx_data_out_o, .rx_data_oe_o,
        .iso_rx_data_out_o, .rx_out_en_n_flt_o(flt_o), .rx_out_en_n_flt_oe_o(flt_oe));
    // ********
    // Shared tasks
    // ********
    // Ends just past the edge so registered outputs have settled
    task tick(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Bounded so a stuck output ends the run instead of hanging it
    task wait_on(input int s, input logic v, output int c);
        c = 0;
        while (mon[s] !== v && c < 400) begin
            @(posedge clk_i);
            #1 c++;
        end
        if (c >= 400) begin
            bad_count++;
            $display("ERROR %0t wait expired", $time);
            report_and_stop;
        end
    endtask
    task wreg(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk_i);
        {addr_i, wr_data_i, wr_stb_i} <= {a, v, 1'b1};
        @(posedge clk_i);
        wr_stb_i <= 1'b0;
    endtask
    task rreg(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk_i);
        {addr_i, rd_stb_i} <= {a, 1'b1};
        @(posedge clk_i);
        rd_stb_i <= 1'b0;
        #1 v = rd_data_o;
    endtask
    // ********
    // Main sequence
    // ********
    initial begin
        {reset_i, host_oe, slew_select_n_i} = 3'h7;
        {tx_bit_in_i, tx_drv_on_i, thermal_trip_i, host_en, rem_on, rem_bit} = 6'h00;
        {wr_stb_i, rd_stb_i, addr_i, wr_data_i} = 12'h000;
        {vcc_mv_i, vcc_iso_mv_i} = {13'h1388, 13'h1388};
        tick(5);
        reset_i <= 1'b0;
        wait_on(2, 1'b0, n);
        rreg(2'h1, d);
        chk(d, 8'h00);
        wreg(2'h1, 8'hff);
        wreg(2'h3, 8'h00);
        rreg(2'h1, d);
        chk(d, 8'h1f);
        rreg(2'h3, d);
        chk(d, 8'h00);
        wreg(2'h1, 8'h00);
        foreach (rows[i]) begin
            {host_en, rem_on, rem_bit, slew_select_n_i} <= rows[i][7:4];
            tick(40);
            chk(rx_data_oe_o, rows[i][3]);
            chk(iso_rx_data_out_o, rows[i][2]);
            chk(rows[i][3] ? rx_data_out_o : 1'b0, rows[i][1]);
            chk(drv_slow_o, rows[i][0]);
        end
        {host_en, rem_on, tx_bit_in_i, tx_drv_on_i, slew_select_n_i} <= 5'h07;
        wait_on(0, 1'b1, n);
        chk(n >= ENA + 3 && n <= ENA + SDIV + 8, 1'b1);
        chk({drv_pos_o, drv_neg_o, iso_rx_data_out_o}, 3'h5);
        tick(200); // bit time of 4 us keeps the host at 250 kBd
        tx_bit_in_i <= 1'b0;
        wait_on(1, 1'b0, nf);
        slew_select_n_i <= 1'b0;
        tick(200);
        tx_bit_in_i <= 1'b1;
        wait_on(1, 1'b1, n);
        chk(n >= nf + 20, 1'b1);
        {slew_select_n_i, tx_drv_on_i, rem_bit} <= 3'h4;
        wait_on(0, 1'b0, n);
        chk(n <= ENA + SDIV + 8, 1'b1);
        wreg(2'h1, 8'h01 << iso_link_pkg::BIT_THERMAL);
        rreg(2'h0, d);
        tx_drv_on_i <= 1'b1;
        wait_on(0, 1'b1, n);
        {thermal_trip_i, rem_on} <= 2'h3;
        wait_on(2, 1'b1, n);
        tick(10);
        chk({drv_oe_o, rx_data_out_o, iso_rx_data_out_o, irq_o}, 4'h5);
        host_oe <= 1'b0;
        tick(8);
        chk({en_pin, rx_data_oe_o}, 2'h2);
        host_oe <= 1'b1;
        rreg(2'h0, d);
        chk(d[iso_link_pkg::BIT_THERMAL], 1'b1);
        tick(2);
        chk(irq_o, 1'b0);
        {thermal_trip_i, addr_i, rem_on} <= 4'h0;
        wait_on(2, 1'b0, n);
        wait_on(0, 1'b1, n);
        wreg(2'h1, 8'h00);
        thermal_trip_i <= 1'b1;
        tick(20);
        chk(irq_o, 1'b0);
        thermal_trip_i <= 1'b0;
        wait_on(0, 1'b1, n);
        vcc_iso_mv_i <= 13'h1004;
        tick(30);
        chk(flt_o, 1'b0);
        vcc_iso_mv_i <= 13'h0f3c;
        wait_on(2, 1'b1, n);
        tick(60);
        chk(drv_oe_o, 1'b0);
        rreg(2'h0, d);
        chk(d[iso_link_pkg::BIT_TIMEOUT], 1'b1);
        rreg(2'h2, d);
        chk(d, 8'h0a);
        vcc_iso_mv_i <= 13'h1004;
        tick(60);
        chk(flt_o, 1'b1);
        vcc_iso_mv_i <= 13'h1388;
        wait_on(2, 1'b0, n);
        vcc_mv_i <= 13'h0f3c;
        wait_on(2, 1'b1, n);
        vcc_mv_i <= 13'h1388;
        wait_on(2, 1'b0, n);
        reset_i <= 1'b1;
        tick(5);
        chk({drv_oe_o, rx_data_oe_o, irq_o, flt_oe}, 4'h0);
        reset_i <= 1'b0;
        wait_on(2, 1'b0, n);
        report_and_stop;
    end
endmodule
`default_nettype wire
